// ==== common/acc_pkg.sv ====
// Constants, field layouts and types of the codec control register bank
package acc_pkg;
	// ------------------------------------------------------------
	// Clock and time base
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned MS_PER_SEC = 1000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_SEC;

	// ------------------------------------------------------------
	// Register map: printed offsets are word indices
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W   = 12;
	localparam logic [3:0]  IDX_CONV = 4'h0;
	localparam logic [3:0]  IDX_GAIN = 4'h1;
	localparam logic [3:0]  IDX_RSVD = 4'he;
	localparam int unsigned IDX_LSB  = 2;
	localparam int unsigned IDX_MSB  = 5;

	localparam logic [15:0] CONV_RESET = 16'h0000;
	localparam logic [15:0] CONV_WMASK = 16'hcf3f;
	localparam logic [15:0] GAIN_RESET = 16'hff00;
	localparam logic [15:0] GAIN_WMASK = 16'hffff;
	localparam logic [7:0]  RSVD_RESET = 8'hff;

	// ------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FMT_I2S   = 2'b00,
		FMT_DSP   = 2'b01,
		FMT_RIGHT = 2'b10,
		FMT_LEFT  = 2'b11
	} acc_fmt_t;

	typedef struct packed {
		logic [1:0] adc_highpass_select;
		logic [1:0] rsv_hi;
		logic [1:0] sample_word_length;
		acc_fmt_t   serial_audio_format;
		logic [1:0] rsv_lo;
		logic [2:0] playback_rate_divider;
		logic [2:0] record_rate_divider;
	} acc_conv_cfg_t;

	typedef struct packed {
		logic       headset_input_mute;
		logic [6:0] headset_input_gain;
		logic [2:0] gain_loop_target_level;
		logic [3:0] gain_loop_time_constants;
		logic       gain_loop_enable;
	} acc_gain_cfg_t;

	typedef enum logic [0:0] {
		LOOP_IDLE  = 1'b0,
		LOOP_TRACK = 1'b1
	} acc_loop_state_t;

	// ------------------------------------------------------------
	// Decoded values (0.5 dB units, 1e-4 Fs units, half divisors)
	// ------------------------------------------------------------
	localparam logic signed [7:0] GAIN_MAX = 8'sh77;
	localparam logic signed [7:0] GAIN_MIN = 8'she8;
	localparam logic [7:0] HPF_C1 = 8'h2d;
	localparam logic [7:0] HPF_C2 = 8'h7d;
	localparam logic [7:0] HPF_C3 = 8'hfa;
	localparam logic [5:0] WL_16  = 6'h10;
	localparam logic [5:0] WL_20  = 6'h14;
	localparam logic [5:0] WL_24  = 6'h18;
	localparam logic [5:0] WL_32  = 6'h20;
	localparam logic [9:0] ATK_MS0 = 10'h008;
	localparam logic [9:0] ATK_MS1 = 10'h00b;
	localparam logic [9:0] ATK_MS2 = 10'h010;
	localparam logic [9:0] ATK_MS3 = 10'h014;
	localparam logic [9:0] DCY_MS0 = 10'h064;
	localparam logic [9:0] DCY_MS1 = 10'h0c8;
	localparam logic [9:0] DCY_MS2 = 10'h190;
	localparam logic [9:0] DCY_MS3 = 10'h1f4;

	// Rate divisor in half steps, shared by both converter fields
	function automatic logic [3:0] rate_half(input logic [2:0] code);
		case (code)
			3'h0:    rate_half = 4'h2;
			3'h1:    rate_half = 4'h3;
			3'h2:    rate_half = 4'h4;
			3'h3:    rate_half = 4'h6;
			3'h4:    rate_half = 4'h8;
			3'h5:    rate_half = 4'ha;
			3'h6:    rate_half = 4'hb;
			default: rate_half = 4'hc;
		endcase
	endfunction
endpackage

// ==== hdl/acc_gain_loop.sv ====
// Automatic gain loop stepping the headset input gain in 0.5 dB steps
`timescale 1ns/1ps
module acc_gain_loop
	import acc_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Settings
	input  wire logic              enable,
	input  wire logic [3:0]        tconst,
	input  wire logic [7:0]        target_mag,
	input  wire logic signed [7:0] seed,
	// Measured level
	input  wire logic              level_valid,
	input  wire logic [7:0]        level_mag,
	// Applied gain
	output logic signed [7:0]      gain_q
);
	localparam int unsigned PW = $clog2(CYC_MS + 1);

	acc_loop_state_t state_q;
	logic [PW-1:0]   pre_q;
	logic [9:0]      wait_q;
	logic [7:0]      level_q;
	logic            seen_q;
	logic [9:0]      atk_ms;
	logic [9:0]      dcy_ms;
	logic            tick;
	logic            loud;
	logic            quiet;
	logic            step_dn;
	logic            step_up;
	int unsigned     since_q;

	always_comb begin
		case (tconst[1:0])
			2'h0:    atk_ms = ATK_MS0;
			2'h1:    atk_ms = ATK_MS1;
			2'h2:    atk_ms = ATK_MS2;
			default: atk_ms = ATK_MS3;
		endcase
		case (tconst[3:2])
			2'h0:    dcy_ms = DCY_MS0;
			2'h1:    dcy_ms = DCY_MS1;
			2'h2:    dcy_ms = DCY_MS2;
			default: dcy_ms = DCY_MS3;
		endcase
		// Millisecond tick from pclk, not from any sample rate
		tick    = (state_q == LOOP_TRACK) && (pre_q == PW'(CYC_MS - 1));
		loud    = seen_q && (level_q < target_mag);
		quiet   = seen_q && (level_q > target_mag);
		step_dn = tick && loud && (wait_q + 10'h001 >= atk_ms);
		step_up = tick && quiet && (wait_q + 10'h001 >= dcy_ms);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= LOOP_IDLE;
		end else begin
			case (state_q)
				LOOP_IDLE:  state_q <= enable ? LOOP_TRACK : LOOP_IDLE;
				LOOP_TRACK: state_q <= enable ? LOOP_TRACK : LOOP_IDLE;
				default:    state_q <= LOOP_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q  <= '0;
			wait_q <= 10'h000;
		end else if (state_q != LOOP_TRACK || tick) begin
			pre_q <= '0;
			if (state_q != LOOP_TRACK || step_dn || step_up ||
			    !(loud || quiet)) begin
				wait_q <= 10'h000;
			end else begin
				wait_q <= wait_q + 10'h001;
			end
		end else begin
			pre_q <= pre_q + PW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 8'h00;
			seen_q  <= 1'b0;
		end else if (!enable) begin
			seen_q <= 1'b0;
		end else if (level_valid) begin
			level_q <= level_mag;
			seen_q  <= 1'b1;
		end
	end

	// Signed gain stays within +59.5 dB and -12 dB after the first clock; reset loads +63.5 dB
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_q <= 8'sh7f;
		end else if (!enable) begin
			// Written codes above +59.5 dB start the loop at its ceiling
			gain_q <= (seed > GAIN_MAX) ? GAIN_MAX : seed;
		end else if (step_dn && gain_q > GAIN_MIN) begin
			gain_q <= gain_q - 8'sh01;
		end else if (step_up && gain_q < GAIN_MAX) begin
			gain_q <= gain_q + 8'sh01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_q <= 0;
		end else if (state_q != LOOP_TRACK || step_dn || step_up) begin
			since_q <= 0;
		end else begin
			since_q <= since_q + 1;
		end
	end

	chk_attack_spacing: assert property (
		@(posedge pclk) disable iff (!presetn)
		step_dn |-> (since_q + 1 >= 32'(atk_ms) * CYC_MS))
	else $error("gain dropped before the attack time");

	chk_decay_spacing: assert property (
		@(posedge pclk) disable iff (!presetn)
		step_up |-> (since_q + 1 >= 32'(dcy_ms) * CYC_MS))
	else $error("gain rose before the decay time");

	chk_gain_bounds: assert property (
		@(posedge pclk) disable iff (!presetn)
		enable && $past(enable) |-> gain_q <= GAIN_MAX && gain_q >= GAIN_MIN)
	else $error("loop gain outside its range");
endmodule

// ==== hdl/acc_ctrl_regs.sv ====
// Converter and headset gain control registers behind an APB slave
//
// Behaviour
// - High-pass code 00 is off; 01, 10, 11 give 0.0045, 0.0125, 0.025 Fs.
// - Word-length codes 00..11 give 16, 20, 24 and 32 bits.
// - Format codes 00..11 give I2S, DSP, right- and left-justified.
// - Playback rate codes 000, 100..111 divide by 1, 4, 5, 5.5 and 6.
// - Record rate codes 000..111 divide by 1, 1.5, 2, 3, 4, 5, 5.5, 6.
// - The headset mute bit mutes at 1, passes at 0 and resets to 1.
// - The seven-bit gain runs from 0 dB in 0.5 dB steps to 59.5 dB; higher codes pass to the stage, up to 63.5 dB.
// - With the loop on, the mute and gain fields read the applied gain.
// - The applied gain reads as signed 0.5 dB steps, +59.5 to -12 dB.
// - Target codes give -5.5, -8, -10, -12, -14, -17, -20, -24 dB.
// - Time constant low bits pick attack, high bits pick decay time.
// - Attack and decay times are fixed in absolute time.
// - Loop enable at 1 drives the gain stage from the loop, else fields.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module acc_ctrl_regs
	import acc_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Measured ADC level, 0.5 dB below full scale
	input  wire logic              level_valid,
	input  wire logic [7:0]        level_mag,
	// Converter settings
	output logic                   hpf_enable,
	output logic [7:0]             hpf_corner,
	output logic [5:0]             word_bits,
	output acc_fmt_t               audio_format,
	output logic [3:0]             dac_div_half,
	output logic [3:0]             adc_div_half,
	// Headset gain stage
	output logic                   pga_mute,
	output logic signed [7:0]      pga_gain,
	output logic                   agc_active
);
	// ------------------------------------------------------------
	// Storage and views
	// ------------------------------------------------------------
	logic [15:0]          conv_q;
	logic [15:0]          gain_q;
	logic [7:0]           rsvd_q;
	acc_conv_cfg_t        conv;
	acc_gain_cfg_t        gcfg;
	logic [7:0]           target_mag_q;
	logic signed [7:0]    loop_gain;

	logic                 access;
	logic                 take;
	logic                 hit;
	logic [3:0]           idx;
	logic [15:0]          rd_val;
	logic                 wr_conv;
	logic                 wr_gain;
	logic                 wr_rsvd;

	logic                 pready_q;
	logic                 pslverr_q;
	logic [31:0]          prdata_q;
	logic                 hpf_enable_q;
	logic [7:0]           hpf_corner_q;
	logic [5:0]           word_bits_q;
	acc_fmt_t             fmt_q;
	logic [3:0]           dac_half_q;
	logic [3:0]           adc_half_q;
	logic                 pga_mute_q;
	logic signed [7:0]    pga_gain_q;
	logic                 agc_active_q;

	// Byte-lane merge restricted to writable bits
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [31:0] wd,
		input logic [3:0]  strb,
		input logic [15:0] wmask
	);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		merge = (old & ~lanes) | (wd[15:0] & lanes);
	endfunction

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	always_comb begin
		conv   = acc_conv_cfg_t'(conv_q);
		gcfg   = acc_gain_cfg_t'(gain_q);
		idx    = paddr[IDX_MSB:IDX_LSB];
		hit    = (paddr[ADDR_W-1:IDX_MSB+1] == '0) &&
		         (idx == IDX_CONV || idx == IDX_GAIN || idx == IDX_RSVD);
		access = psel && penable;
		take   = access && pready_q;
		wr_conv = take && pwrite && (idx == IDX_CONV) && hit;
		wr_gain = take && pwrite && (idx == IDX_GAIN) && hit;
		wr_rsvd = take && pwrite && (idx == IDX_RSVD) && hit;
		case (idx)
			IDX_CONV: rd_val = conv_q;
			IDX_GAIN: begin
				// Loop on: upper byte is the applied signed gain
				rd_val = gcfg.gain_loop_enable ?
				         {loop_gain, gain_q[7:0]} : gain_q;
			end
			IDX_RSVD: rd_val = {rsvd_q, 8'h00};
			default:  rd_val = 16'h0000;
		endcase
	end

	// One wait state so read data can come from a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (access && !pready_q) begin
			pready_q  <= 1'b1;
			pslverr_q <= !hit;
			prdata_q  <= (hit && !pwrite) ? {16'h0000, rd_val} : 32'h0;
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_q <= CONV_RESET;
		end else if (wr_conv) begin
			conv_q <= merge(conv_q, pwdata, pstrb, CONV_WMASK);
		end
	end

	// Written mute and gain are kept while the loop runs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_q <= GAIN_RESET;
		end else if (wr_gain) begin
			gain_q <= merge(gain_q, pwdata, pstrb, GAIN_WMASK);
		end
	end

	// Stored as written; software keeps it at all ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsvd_q <= RSVD_RESET;
		end else if (wr_rsvd && pstrb[1]) begin
			rsvd_q <= pwdata[15:8];
		end
	end

	// ------------------------------------------------------------
	// Converter setting decode
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hpf_enable_q <= 1'b0;
			hpf_corner_q <= 8'h00;
		end else begin
			hpf_enable_q <= conv.adc_highpass_select != 2'b00;
			case (conv.adc_highpass_select)
				2'b01:   hpf_corner_q <= HPF_C1;
				2'b10:   hpf_corner_q <= HPF_C2;
				2'b11:   hpf_corner_q <= HPF_C3;
				default: hpf_corner_q <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_bits_q <= WL_16;
		end else begin
			case (conv.sample_word_length)
				2'b00:   word_bits_q <= WL_16;
				2'b01:   word_bits_q <= WL_20;
				2'b10:   word_bits_q <= WL_24;
				default: word_bits_q <= WL_32;
			endcase
		end
	end

	// Rate ratio check for right-justified is left to software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_q <= FMT_I2S;
		end else begin
			fmt_q <= conv.serial_audio_format;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_half_q <= 4'h2;
			adc_half_q <= 4'h2;
		end else begin
			dac_half_q <= rate_half(conv.playback_rate_divider);
			adc_half_q <= rate_half(conv.record_rate_divider);
		end
	end

	// ------------------------------------------------------------
	// Gain loop and gain stage
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			target_mag_q <= 8'h0b;
		end else begin
			case (gcfg.gain_loop_target_level)
				3'h0:    target_mag_q <= 8'h0b;
				3'h1:    target_mag_q <= 8'h10;
				3'h2:    target_mag_q <= 8'h14;
				3'h3:    target_mag_q <= 8'h18;
				3'h4:    target_mag_q <= 8'h1c;
				3'h5:    target_mag_q <= 8'h22;
				3'h6:    target_mag_q <= 8'h28;
				default: target_mag_q <= 8'h30;
			endcase
		end
	end

	acc_gain_loop #(
		.CYC_MS      (CYC_MS)
	) u_loop (
		.pclk        (pclk),
		.presetn     (presetn),
		.enable      (gcfg.gain_loop_enable),
		.tconst      (gcfg.gain_loop_time_constants),
		.target_mag  (target_mag_q),
		.seed        ({1'b0, gcfg.headset_input_gain}),
		.level_valid (level_valid),
		.level_mag   (level_mag),
		.gain_q      (loop_gain)
	);

	// Loop drives the stage when enabled, else the written fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pga_mute_q   <= 1'b1;
			pga_gain_q   <= 8'sh7f;
			agc_active_q <= 1'b0;
		end else if (gcfg.gain_loop_enable) begin
			pga_mute_q   <= 1'b0;
			pga_gain_q   <= loop_gain;
			agc_active_q <= 1'b1;
		end else begin
			pga_mute_q   <= gcfg.headset_input_mute;
			pga_gain_q   <= {1'b0, gcfg.headset_input_gain};
			agc_active_q <= 1'b0;
		end
	end

	always_comb begin
		prdata       = prdata_q;
		pready       = pready_q;
		pslverr      = pslverr_q;
		hpf_enable   = hpf_enable_q;
		hpf_corner   = hpf_corner_q;
		word_bits    = word_bits_q;
		audio_format = fmt_q;
		dac_div_half = dac_half_q;
		adc_div_half = adc_half_q;
		pga_mute     = pga_mute_q;
		pga_gain     = pga_gain_q;
		agc_active   = agc_active_q;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_hpf_corner: assert property (
		@(posedge pclk) disable iff (!presetn)
		conv.adc_highpass_select == 2'b10 |=>
		hpf_enable && hpf_corner == 8'h7d)
	else $error("high-pass corner mismatch");

	chk_word_len: assert property (
		@(posedge pclk) disable iff (!presetn)
		conv.sample_word_length == 2'b01 |=> word_bits == 6'h14)
	else $error("word length mismatch");

	chk_format_sel: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_conv && pstrb[1] && pwdata[9:8] == 2'b10 |=>
		##1 audio_format == FMT_RIGHT)
	else $error("format not applied after write");

	chk_dac_rate: assert property (
		@(posedge pclk) disable iff (!presetn)
		conv.playback_rate_divider == 3'h1 |=> dac_div_half == 4'h3)
	else $error("playback divisor mismatch");

	chk_adc_rate: assert property (
		@(posedge pclk) disable iff (!presetn)
		conv.record_rate_divider == 3'h6 |=> adc_div_half == 4'hb)
	else $error("record divisor mismatch");

	chk_gain_manual: assert property (
		@(posedge pclk) disable iff (!presetn)
		!gcfg.gain_loop_enable |=>
		pga_mute == $past(gcfg.headset_input_mute) &&
		pga_gain == $signed({1'b0, $past(gcfg.headset_input_gain)}))
	else $error("gain stage does not follow written fields");

	chk_agc_readback: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !pready_q && !pwrite && hit && idx == IDX_GAIN &&
		gcfg.gain_loop_enable |=> prdata[15:8] == $past(loop_gain))
	else $error("gain readback is not the applied gain");

	chk_target_level: assert property (
		@(posedge pclk) disable iff (!presetn)
		gcfg.gain_loop_target_level == 3'h5 |=> target_mag_q == 8'h22)
	else $error("target level mismatch");

	chk_apb_wait: assert property (
		@(posedge pclk) disable iff (!presetn)
		access && !pready_q |=> pready && pslverr == !$past(hit))
	else $error("bus answer late or wrong");
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the codec control register bank
`timescale 1ns/1ps
module testbench;
	import acc_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	// Reference rate range is kept by the board clocking
	localparam int unsigned TB_MS = 4;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [3:0]        pstrb = '0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              level_valid = 1'b0;
	logic [7:0]        level_mag = 8'h00;
	logic              hpf_enable;
	logic [7:0]        hpf_corner;
	logic [5:0]        word_bits;
	acc_fmt_t          audio_format;
	logic [3:0]        dac_div_half;
	logic [3:0]        adc_div_half;
	logic              pga_mute;
	logic signed [7:0] pga_gain;
	logic              agc_active;
	int                n_mismatch = 0;
	int                num_checks = 0;
	int                cycles = 0;

	acc_ctrl_regs #(.CYC_MS(TB_MS)) i_acc_ctrl_regs (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.level_valid(level_valid), .level_mag(level_mag),
		.hpf_enable(hpf_enable), .hpf_corner(hpf_corner),
		.word_bits(word_bits), .audio_format(audio_format),
		.dac_div_half(dac_div_half), .adc_div_half(adc_div_half),
		.pga_mute(pga_mute), .pga_gain(pga_gain), .agc_active(agc_active)
	);

	// ------------------------------------------------------------
	// Clock, reset and hang guard
	// ------------------------------------------------------------
	initial begin
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			n_mismatch++;
			$display("unexpected run length, limit of 6000 cycles reached");
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	// Request held until pready is sampled high; one wait state expected
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [15:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("apb latency", 32'h2, 32'(n));
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d,
		input logic [3:0] s);
		logic [31:0] rd;
		logic        err;
		apb(1'b1, a, d, s, rd, err);
	endtask

	task automatic rd_chk(input string nm, input logic [11:0] a,
		input logic [15:0] e, input logic e_err);
		logic [31:0] rd;
		logic        err;
		apb(1'b0, a, 16'h0000, 4'h0, rd, err);
		chk(nm, {16'h0000, e}, rd);
		chk({nm, " error"}, 32'(e_err), 32'(err));
	endtask

	// Decoded outputs lag their register by a cycle
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic lvl(input logic [7:0] m);
		@(posedge pclk);
		level_valid <= 1'b1;
		level_mag <= m;
		@(posedge pclk);
		level_valid <= 1'b0;
	endtask

	task automatic chk_stage(input logic m, input logic [7:0] g,
		input logic a);
		chk("pga_mute", 32'(m), 32'(pga_mute));
		chk("pga_gain", {24'h000000, g}, {24'h000000, pga_gain});
		chk("agc_active", 32'(a), 32'(agc_active));
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		#1;
		chk_stage(1'b1, 8'h7f, 1'b0);
		chk("word_bits", 32'h10, 32'(word_bits));
		rd_chk("conv", 12'h000, 16'h0000, 1'b0);
		rd_chk("gain", 12'h004, 16'hff00, 1'b0);
		rd_chk("rsvd", 12'h038, 16'hff00, 1'b0);
		wr(12'h038, 16'hff00, 4'h3);
		rd_chk("rsvd", 12'h038, 16'hff00, 1'b0);
		$display("test reset done");
	endtask

	task automatic test_conv();
		logic [15:0] c;
		logic [7:0]  corner [4] = '{8'h00, 8'h2d, 8'h7d, 8'hfa};
		logic [5:0]  wbits [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
		logic [3:0]  half [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha,
			4'hb, 4'hc};
		for (int i = 0; i < 8; i++) begin
			// Reserved bits written as ones must not stick
			c = {2'(i), 2'b11, 2'(i), 2'(i), 2'b11, 3'(i), 3'(12 - i)};
			wr(12'h000, c, 4'hf);
			settle();
			chk("hpf_enable", 32'(i % 4 != 0), 32'(hpf_enable));
			chk("hpf_corner", 32'(corner[i % 4]), 32'(hpf_corner));
			chk("word_bits", 32'(wbits[i % 4]), 32'(word_bits));
			chk("format", 32'(i % 4), 32'(audio_format));
			chk("dac_div", 32'(half[i]), 32'(dac_div_half));
			chk("adc_div", 32'(half[3'(12 - i)]), 32'(adc_div_half));
			rd_chk("conv", 12'h000, c & 16'hcf3f, 1'b0);
		end
		$display("test converter fields done");
	endtask

	task automatic test_unmapped();
		logic [31:0] rd;
		logic        err;
		rd_chk("unmapped", 12'h008, 16'h0000, 1'b1);
		apb(1'b1, 12'h040, 16'h0000, 4'hf, rd, err);
		chk("unmapped write error", 32'h1, 32'(err));
		rd_chk("alias dropped", 12'h000, 16'hcf3d, 1'b0);
		$display("test unmapped done");
	endtask

	task automatic test_manual_gain();
		wr(12'h004, 16'h7700, 4'hf);
		settle();
		chk_stage(1'b0, 8'h77, 1'b0);
		wr(12'h004, 16'h0000, 4'h1);
		rd_chk("gain strobe", 12'h004, 16'h7700, 1'b0);
		wr(12'h004, 16'h8000, 4'hf);
		settle();
		chk_stage(1'b1, 8'h00, 1'b0);
		$display("test manual gain done");
	endtask

	// Attack 8 ms and decay 100 ms are 32 and 400 cycles here
	task automatic test_loop();
		wr(12'h004, 16'h0001, 4'hf);
		settle();
		lvl(8'h05);
		repeat (20) @(posedge pclk);
		#1;
		chk_stage(1'b0, 8'h00, 1'b1);
		repeat (800) @(posedge pclk);
		#1;
		chk_stage(1'b0, 8'he8, 1'b1);
		rd_chk("loop read", 12'h004, 16'he801, 1'b0);
		lvl(8'h0b);
		// Equal level must span a ms tick to clear the wait
		repeat (TB_MS) @(posedge pclk);
		lvl(8'hc8);
		repeat (380) @(posedge pclk);
		#1;
		chk_stage(1'b0, 8'he8, 1'b1);
		repeat (60) @(posedge pclk);
		#1;
		chk_stage(1'b0, 8'he9, 1'b1);
		wr(12'h004, 16'h3c00, 4'hf);
		settle();
		chk_stage(1'b0, 8'h3c, 1'b0);
		rd_chk("loop off read", 12'h004, 16'h3c00, 1'b0);
		$display("test gain loop done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_conv();
		test_unmapped();
		test_manual_gain();
		test_loop();
		complete_run();
	end
endmodule
